// ### design/pwv_channel_out.sv
// Purpose: compare one channel's active width against the period counter
// Assumes: width and modulus only change at a load edge
// Notes: output registered, so it trails the counter by one cycle
`timescale 1ns/100ps
module pwv_channel_out (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // active settings and count
    input wire pwv_pkg::pwv_width_t i_width,
    input wire pwv_pkg::pwv_word_t i_modulus,
    input wire pwv_pkg::pwv_word_t i_count,
    // channel pin level
    output logic o_out
);
    import pwv_pkg::*;

    logic signed [16:0] width_ext;
    logic signed [16:0] mod_ext;
    logic level_d;
    logic out_q;

    // seventeen bits so a modulus with its top bit set stays positive
    assign width_ext = {i_width[15], i_width};
    assign mod_ext = {1'b0, i_modulus};

    // level decision for the current count
    always_comb begin
        if (width_ext <= 17'sh00000) begin
            level_d = 1'b0;
        end else if (width_ext >= mod_ext) begin
            level_d = 1'b1;
        end else begin
            level_d = (i_count < i_width[15:0]);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            out_q <= 1'b0;
        end else begin
            out_q <= level_d;
        end
    end

    assign o_out = out_q;
endmodule

// ### design/pwv_map.svh
// Purpose: register offsets, field positions and reset values of the pulse width block
// Assumes: word-wide register port with a four bit address
// Notes: definitions only, no logic
`ifndef PWV_MAP_SVH
`define PWV_MAP_SVH

// channel width buffers, one word each
`define PWV_OFS_CH1 4'h0
`define PWV_OFS_CH2 4'h1
`define PWV_OFS_CH3 4'h2
`define PWV_OFS_CH4 4'h3
// counter modulus buffer
`define PWV_OFS_MOD 4'h4
// control word holding the load okay bit
`define PWV_OFS_CTRL 4'h5
// read only view of the period counter
`define PWV_OFS_CNT 4'h6

// field positions in the control word
`define PWV_CTRL_LOAD_OKAY_BIT 0

// reset values
`define PWV_RST_WIDTH 16'h0000
`define PWV_RST_MOD 16'h0010
`define PWV_RST_WORD 16'h0000

`endif

// ### design/pwv_period_counter.sv
// Purpose: free running period counter that marks the load cycle
// Assumes: one channel clock period per system clock
// Notes: a modulus of zero or one reloads on every cycle
`timescale 1ns/100ps
`include "pwv_map.svh"
module pwv_period_counter (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // active modulus
    input wire pwv_pkg::pwv_word_t i_modulus,
    // count and load cycle marker
    output pwv_pkg::pwv_word_t o_count,
    output logic o_load
);
    import pwv_pkg::*;

    pwv_word_t count_q;
    logic last_w;

    // last count of the period; tiny moduli collapse to a one cycle period
    assign last_w = (i_modulus <= 16'h0001) || (count_q >= (i_modulus - 16'h0001));
    assign o_load = last_w;
    assign o_count = count_q;

    // count 0 .. modulus-1, then wrap at the load edge
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            count_q <= `PWV_RST_WORD;
        end else if (last_w) begin
            count_q <= `PWV_RST_WORD;
        end else begin
            count_q <= count_q + 16'h0001;
        end
    end
endmodule

// ### design/pwv_pkg.sv
// Purpose: shared types of the pulse width block
// Assumes: sixteen bit register words
// Notes: offsets and reset values live in pwv_map.svh
package pwv_pkg;
    // raw bus word
    typedef logic [15:0] pwv_word_t;
    // signed pulse width in channel clock periods
    typedef logic signed [15:0] pwv_width_t;
    // register address
    typedef logic [3:0] pwv_addr_t;
endpackage

// ### design/pwv_pulse_width_regs.sv
// Purpose: buffered pulse width registers and outputs for channels one to four
// Assumes: register port master never asserts read and write together
// Notes: widths and modulus are adopted together at the load cycle
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "pwv_map.svh"
module pwv_pulse_width_regs (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register port
    input wire pwv_pkg::pwv_addr_t i_addr,
    input wire pwv_pkg::pwv_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output pwv_pkg::pwv_word_t o_rdata,
    // channel pins
    output logic o_channel_one_output,
    output logic o_channel_two_output,
    output logic o_channel_three_output,
    output logic o_channel_four_output
);
    import pwv_pkg::*;

    // buffered and active widths
    pwv_width_t buf_q [4];
    pwv_width_t act_q [4];
    // buffered and active modulus
    pwv_word_t mod_buf_q;
    pwv_word_t mod_act_q;
    // load okay flag
    logic load_okay_q;
    // period counter outputs
    pwv_word_t count_w;
    logic load_cyc_w;
    // pin levels per channel
    logic [3:0] ch_out_w;
    // registered read data
    pwv_word_t rdata_q;
    // decoded write target
    logic [2:0] wr_sel_w;
    logic ctrl_wr_w;
    logic load_now_w;

    // hit flag in bit 2, channel index below
    function automatic logic [2:0] chan_sel(input pwv_addr_t addr);
        logic [2:0] sel;
        sel = 3'h0;
        case (addr)
            `PWV_OFS_CH1: sel = 3'h4;
            `PWV_OFS_CH2: sel = 3'h5;
            `PWV_OFS_CH3: sel = 3'h6;
            `PWV_OFS_CH4: sel = 3'h7;
            default: sel = 3'h0;
        endcase
        return sel;
    endfunction

    // write decode
    assign wr_sel_w = chan_sel(i_addr);
    assign ctrl_wr_w = i_wr && (i_addr == `PWV_OFS_CTRL);
    assign load_now_w = load_cyc_w && load_okay_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 4; k++) begin
                buf_q[k] <= `PWV_RST_WIDTH;
            end
        end else if (i_wr && wr_sel_w[2]) begin
            buf_q[wr_sel_w[1:0]] <= pwv_width_t'(i_wdata);
        end
    end

    // modulus buffer, adopted alongside the widths
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            mod_buf_q <= `PWV_RST_MOD;
        end else if (i_wr && (i_addr == `PWV_OFS_MOD)) begin
            mod_buf_q <= i_wdata;
        end
    end

    // set by write, cleared by load
    // a software write in the load cycle wins, so a fresh one is never lost
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            load_okay_q <= 1'b0;
        end else if (ctrl_wr_w) begin
            load_okay_q <= i_wdata[`PWV_CTRL_LOAD_OKAY_BIT];
        end else if (load_now_w) begin
            load_okay_q <= 1'b0;
        end
    end

    // adopt buffers at load cycle
    // a buffer write in the same cycle misses this load and waits for the next
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 4; k++) begin
                act_q[k] <= `PWV_RST_WIDTH;
            end
            mod_act_q <= `PWV_RST_MOD;
        end else if (load_now_w) begin
            for (int k = 0; k < 4; k++) begin
                act_q[k] <= buf_q[k];
            end
            mod_act_q <= mod_buf_q;
        end
    end

    // reads return buffers, the load okay flag or the period count
    // data stands only in the cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rdata_q <= `PWV_RST_WORD;
        end else if (i_rd) begin
            if (chan_sel(i_addr) != 3'h0) begin
                rdata_q <= pwv_word_t'(buf_q[i_addr[1:0]]);
            end else if (i_addr == `PWV_OFS_MOD) begin
                rdata_q <= mod_buf_q;
            end else if (i_addr == `PWV_OFS_CTRL) begin
                rdata_q <= {15'h0000, load_okay_q};
            end else if (i_addr == `PWV_OFS_CNT) begin
                rdata_q <= count_w;
            end else begin
                rdata_q <= `PWV_RST_WORD; // unmapped reads as zero
            end
        end else begin
            rdata_q <= `PWV_RST_WORD;
        end
    end

    assign o_rdata = rdata_q;

    // shared period counter for all four channels
    pwv_period_counter u_counter (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_modulus(mod_act_q),
        .o_count(count_w),
        .o_load(load_cyc_w)
    );

    // one comparator per channel
    for (genvar g = 0; g < 4; g++) begin : gen_chan
        pwv_channel_out u_out (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(i_rst_n),
            .i_width(act_q[g]),
            .i_modulus(mod_act_q),
            .i_count(count_w),
            .o_out(ch_out_w[g])
        );
    end

    // pin mapping
    assign o_channel_one_output = ch_out_w[0];
    assign o_channel_two_output = ch_out_w[1];
    assign o_channel_three_output = ch_out_w[2];
    assign o_channel_four_output = ch_out_w[3];

    // ------------------------------------------------------------------
    // checks on the register file and the pins
    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // write to a width register followed by a read of the same address
    sequence s_wr_chan;
        i_wr && (chan_sel(i_addr) != 3'h0);
    endsequence

    sequence s_rd_same;
        i_rd && (i_addr == $past(i_addr));
    endsequence

    property p_rd_buf;
        s_wr_chan ##1 s_rd_same |=> (o_rdata == $past(i_wdata, 2));
    endproperty
    a_rd_buf: assert property (p_rd_buf)
        else $error("width readback differs from written value");

    // read data is zero when no read was made
    property p_rd_idle;
        !i_rd |=> (o_rdata == 16'h0000);
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data present without a read strobe");

    // load okay set by a write of one
    property p_lok_set;
        ctrl_wr_w && i_wdata[`PWV_CTRL_LOAD_OKAY_BIT] |=> load_okay_q;
    endproperty
    a_lok_set: assert property (p_lok_set)
        else $error("load okay not set by software write");

    // load okay cleared after a load with no competing write
    property p_lok_clr;
        load_now_w && !ctrl_wr_w |=> !load_okay_q;
    endproperty
    a_lok_clr: assert property (p_lok_clr)
        else $error("load okay not cleared after load");

    // without load okay the active modulus never moves
    property p_mod_hold;
        !load_okay_q |=> $stable(mod_act_q);
    endproperty
    a_mod_hold: assert property (p_mod_hold)
        else $error("active modulus changed without load okay");

    // a write of zero withdraws load okay before the reload
    property p_lok_wr0;
        ctrl_wr_w && !i_wdata[`PWV_CTRL_LOAD_OKAY_BIT] |=> !load_okay_q;
    endproperty
    a_lok_wr0: assert property (p_lok_wr0)
        else $error("load okay not cleared by software write");

    // load okay moves only on a control write or a load
    property p_lok_hold;
        !ctrl_wr_w && !load_now_w |=> $stable(load_okay_q);
    endproperty
    a_lok_hold: assert property (p_lok_hold)
        else $error("load okay changed on its own");

    // control read shows the flag as it stood at the strobe
    property p_rd_ctrl;
        i_rd && (i_addr == `PWV_OFS_CTRL) |=> (o_rdata == {15'h0000, $past(load_okay_q)});
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control readback differs from load okay");

    // a load adopts the buffered modulus together with the widths
    property p_mod_load;
        load_now_w |=> (mod_act_q == $past(mod_buf_q));
    endproperty
    a_mod_load: assert property (p_mod_load)
        else $error("load did not adopt buffered modulus");

    // modulus buffer changes only through its own write
    property p_mod_buf_hold;
        !(i_wr && (i_addr == `PWV_OFS_MOD)) |=> $stable(mod_buf_q);
    endproperty
    a_mod_buf_hold: assert property (p_mod_buf_hold)
        else $error("modulus buffer changed without its own write");

    // count stays below a modulus above one, so such a period is modulus cycles long
    property p_cnt_range;
        (mod_act_q > 16'h0001) |-> (count_w < mod_act_q);
    endproperty
    a_cnt_range: assert property (p_cnt_range)
        else $error("period count reached the modulus");

    // the load cycle closes a period and the next one starts at zero
    sequence s_period_end;
        load_cyc_w;
    endsequence

    sequence s_period_start;
        count_w == 16'h0000;
    endsequence

    property p_cnt_wrap;
        s_period_end |=> s_period_start;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap)
        else $error("period count did not restart after the load cycle");

    for (genvar c = 0; c < 4; c++) begin : gen_chk
        // buffer changes only through a write to its own address
        property p_buf_hold;
            !(i_wr && (chan_sel(i_addr) == {1'b1, 2'(c)})) |=> $stable(buf_q[c]);
        endproperty
        a_buf_hold: assert property (p_buf_hold)
            else $error("width buffer changed without its own write");

        // a channel read returns that channel's buffer
        property p_rd_chan;
            i_rd && (i_addr == pwv_addr_t'(c)) |=> (o_rdata == pwv_word_t'($past(buf_q[c])));
        endproperty
        a_rd_chan: assert property (p_rd_chan)
            else $error("width readback differs from its buffer");

        // a channel write lands in its buffer whatever else is going on
        property p_wr_chan;
            i_wr && (i_addr == pwv_addr_t'(c)) |=> (buf_q[c] == pwv_width_t'($past(i_wdata)));
        endproperty
        a_wr_chan: assert property (p_wr_chan)
            else $error("width write not taken by its buffer");

        // active width stays put until a load with load okay
        property p_act_hold;
            !load_now_w |=> $stable(act_q[c]);
        endproperty
        a_act_hold: assert property (p_act_hold)
            else $error("active width changed outside a load");

        // load copies the buffered width
        property p_act_load;
            load_now_w |=> (act_q[c] == $past(buf_q[c]));
        endproperty
        a_act_load: assert property (p_act_load)
            else $error("load did not adopt buffered width");

        // negative width, even with a large magnitude, keeps the pin low
        property p_neg_off;
            act_q[c][15] ##1 act_q[c][15] |=> !ch_out_w[c];
        endproperty
        a_neg_off: assert property (p_neg_off)
            else $error("negative width drove the pin high");

        // zero width keeps the pin low
        property p_zero_off;
            (act_q[c] == 16'sh0000) ##1 (act_q[c] == 16'sh0000) |=> !ch_out_w[c];
        endproperty
        a_zero_off: assert property (p_zero_off)
            else $error("zero width drove the pin high");

        // positive width at or above modulus keeps the pin high
        property p_full_on;
            (act_q[c] > 16'sh0000) && // a zero modulus leaves a zero width low
            ($signed({act_q[c][15], act_q[c]}) >= $signed({1'b0, mod_act_q}))
                |=> ch_out_w[c];
        endproperty
        a_full_on: assert property (p_full_on)
            else $error("full width did not hold the pin high");

        // inside the range the pin is high while the count is below width
        property p_mid_high;
            (act_q[c] > 16'sh0000) && ($signed({1'b0, act_q[c]}) < $signed({1'b0, mod_act_q}))
                && (count_w < act_q[c][15:0]) |=> ch_out_w[c];
        endproperty
        a_mid_high: assert property (p_mid_high)
            else $error("pin low inside the active part of the period");

        // and low once the count reaches the width
        property p_mid_low;
            (act_q[c] > 16'sh0000) && ($signed({1'b0, act_q[c]}) < $signed({1'b0, mod_act_q}))
                && (count_w >= act_q[c][15:0]) |=> !ch_out_w[c];
        endproperty
        a_mid_low: assert property (p_mid_low)
            else $error("pin high in the inactive part of the period");
    end
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for the buffered pulse width registers
// Assumes: one channel clock per system clock, pins trail the counter by one cycle
// Notes: pins are judged by high counts over two whole periods, so phase does not matter
`timescale 1ns/100ps
`include "pwv_map.svh"
module tb;
    import pwv_pkg::*;
    // clock, reset and register port
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    pwv_addr_t i_addr = 4'h0;
    pwv_word_t i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    pwv_word_t o_rdata;
    wire [3:0] pins;
    // bookkeeping
    int err_total = 0;
    int tests_run = 0;
    pwv_word_t exp_q[$];
    logic rd_q = 1'b0;
    logic rd_qq = 1'b0;
    int act_w[4];
    int pend[4];
    int act_mod;

    // 20 mhz system clock
    always #25 i_clk_sys = ~i_clk_sys;

    pwv_pulse_width_regs u_dut (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_channel_one_output(pins[0]),
        .o_channel_two_output(pins[1]),
        .o_channel_three_output(pins[2]),
        .o_channel_four_output(pins[3])
    );

    // single compare point, case equality so unknowns never match
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe, zero after that
    always @(posedge i_clk_sys) begin
        if (rd_q) begin
            check("rdata", o_rdata, exp_q.pop_front());
        end else if (rd_qq) begin
            check("rdata idle", o_rdata, 16'h0000);
        end
        rd_qq <= rd_q;
        rd_q <= i_rd;
    end

    // every task sets both strobes once, so back-to-back calls never double assign
    task automatic wr(input pwv_addr_t a, input pwv_word_t d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic rd(input pwv_addr_t a, input pwv_word_t exp);
        exp_q.push_back(exp);
        i_addr <= a;
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
    endtask

    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
    endtask

    function automatic int expect_high(input int w, input int m);
        if (w <= 0) return 0;
        if (w >= m) return m;
        return w;
    endfunction

    // settle one period, then count high samples over two periods
    task automatic measure();
        logic [15:0] cnt[4];
        idle(act_mod + 2);
        for (int i = 0; i < 4; i++) cnt[i] = 16'h0000;
        repeat (2 * act_mod) begin
            @(posedge i_clk_sys);
            for (int i = 0; i < 4; i++) cnt[i] = cnt[i] + {15'h0000, pins[i]};
        end
        for (int i = 0; i < 4; i++) begin
            check("high count", cnt[i], 16'(2 * expect_high(act_w[i], act_mod)));
        end
    endtask

    // buffered widths stay pending until apply sets load okay and the next load cycle adopts them
    task automatic write_widths();
        // each read straight after its write, so readback follows the buffer
        for (int i = 0; i < 4; i++) begin
            wr(pwv_addr_t'(i), 16'(pend[i]));
            rd(pwv_addr_t'(i), 16'(pend[i]));
        end
    endtask

    task automatic apply(input int m);
        // software arms load okay only after reading it clear
        rd(`PWV_OFS_CTRL, 16'h0000);
        wr(`PWV_OFS_CTRL, 16'h0001);
        idle(act_mod + 4);
        act_w = pend;
        act_mod = m;
        rd(`PWV_OFS_CTRL, 16'h0000);
        measure();
    endtask

    initial begin
        int m;
        void'($urandom(50835));
        act_mod = 16;
        act_w = '{0, 0, 0, 0};
        repeat (6) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        idle(1);
        // reset contents, unmapped place and all-low pins
        for (int i = 0; i < 4; i++) rd(pwv_addr_t'(i), `PWV_RST_WIDTH);
        rd(`PWV_OFS_MOD, `PWV_RST_MOD);
        wr(`PWV_OFS_CTRL, 16'h0000);
        rd(`PWV_OFS_CTRL, `PWV_RST_WORD);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
        // counter restarted at the last reset edge, ten counts ago at this read
        rd(`PWV_OFS_CNT, 16'h000a);
        measure();
        // inside range, negative, equal to modulus, random inside
        pend = '{4, -3, 16, 1 + int'($urandom_range(14))};
        write_widths();
        measure();
        apply(16);
        // shrink modulus; old widths stay in use until load
        pend = '{8, 0, 7, -32768};
        wr(`PWV_OFS_MOD, 16'h0008);
        write_widths();
        rd(`PWV_OFS_MOD, 16'h0008);
        measure();
        apply(8);
        // random widths around zero and the modulus
        repeat (4) begin
            m = 2 + int'($urandom_range(14));
            for (int i = 0; i < 4; i++) pend[i] = int'($urandom_range(40)) - 20;
            wr(`PWV_OFS_MOD, 16'(m));
            write_widths();
            apply(m);
        end
        idle(3);
        summarize();
    end

    // hang guard, several times the expected run length
    initial begin
        repeat (6000) @(posedge i_clk_sys);
        err_total++;
        summarize();
    end
endmodule
